// ==== vectored_interrupt_priority.v ====
// vectored interrupt priority resolver with software break interrupt
`timescale 1ns/1ps
`include "irq_consts.vh"
module vectored_interrupt_priority (
    input  wire                 clk_i,
    input  wire                 resetn_i,
    input  wire                 ce_i,
    input  wire [`WDT_W-1:0]    wdt_count_i,
    input  wire [`WDT_W-1:0]    wdt_overflow_i,
    input  wire [7:0]           option_byte_i,
    input  wire [7:0]           low_voltage_detect_reg_i,
    input  wire                 low_voltage_irq_i,
    input  wire                 ext_pin_zero_irq_i,
    input  wire                 ext_pin_four_irq_i,
    input  wire                 ext_pin_five_irq_i,
    input  wire                 ext_pin_ten_irq_i,
    input  wire [3:0]           pin_rise_en_i,
    input  wire [3:0]           pin_fall_en_i,
    input  wire                 lin_port_tx_irq_i,
    input  wire                 lin_port_rx_irq_i,
    input  wire                 lin_port_rx_err_irq_i,
    input  wire                 dma_ch_zero_done_irq_i,
    input  wire                 dma_ch_one_done_irq_i,
    input  wire                 radio_link_serial_irq_i,
    input  wire                 radio_link_buf_empty_i,
    input  wire                 multi_port_async_tx_irq_i,
    input  wire                 multi_port_sync_irq_i,
    input  wire                 multi_port_sync_empty_i,
    input  wire                 multi_port_twowire_irq_i,
    input  wire                 multi_port_rx_irq_i,
    input  wire                 multi_port_rx_err_irq_i,
    input  wire                 timer_u0_ch0_irq_i,
    input  wire                 timer_u0_ch1_irq_i,
    input  wire                 timer_u0_ch2_irq_i,
    input  wire                 timer_u0_ch3_irq_i,
    input  wire                 timer_u0_ch4_irq_i,
    input  wire                 timer_u0_ch5_irq_i,
    input  wire                 timer_u0_ch6_irq_i,
    input  wire                 timer_u0_ch7_irq_i,
    input  wire                 timer_u1_ch0_irq_i,
    input  wire                 timer_u1_ch1_irq_i,
    input  wire                 timer_u1_ch2_irq_i,
    input  wire                 timer_u1_ch3_irq_i,
    input  wire                 rtc_fixed_cycle_i,
    input  wire                 rtc_alarm_match_i,
    input  wire                 rtc_interval_irq_i,
    input  wire                 tx_only_port_irq_i,
    input  wire                 divide_done_irq_i,
    input  wire                 software_break_instruction_i,
    input  wire [`NUM_SRC-1:0]  mask_i,
    input  wire [`NUM_SRC-1:0]  flag_clear_i,
    input  wire                 cpu_int_enable_i,
    input  wire                 cpu_ack_i,
    output reg                  int_req_o,
    output reg  [`VEC_W-1:0]    int_vector_o,
    output reg  [`IDX_W-1:0]    int_priority_o,
    output reg                  int_software_o,
    output reg  [`NUM_SRC-1:0]  pending_o
);
    localparam [1:0] ST_IDLE    = 2'b00;
    localparam [1:0] ST_FETCH   = 2'b01;
    localparam [1:0] ST_LOAD    = 2'b10;
    localparam [1:0] ST_PRESENT = 2'b11;

    reg  [1:0]          state_q;
    reg  [1:0]          state_d;
    reg  [`NUM_SRC-1:0] pend_q;
    reg  [`NUM_SRC-1:0] pend_d;
    reg  [`NUM_SRC-1:0] ev;
    reg  [`NUM_SRC-1:0] ack_clr;
    reg  [`IDX_W-1:0]   idx_q;
    reg  [`IDX_W-1:0]   idx_d;
    reg                 sw_pend_q;
    reg                 sw_pend_d;
    reg                 is_sw_d;
    reg                 req_d;
    reg  [`VEC_W-1:0]   vec_d;
    reg  [`IDX_W-1:0]   prio_d;
    reg  [`WDT_W-1:0]   wdt_prev_q;
    wire [`WDT_W-1:0]   wdt_thresh;
    wire                wdt_hit;
    wire [3:0]          pin_edge;
    wire [3:0]          pin_raw;
    wire [`VEC_W-1:0]   rom_data;
    wire [`NUM_SRC-1:0] cand;
    wire [`IDX_W-1:0]   winner;
    wire                cand_any;
    wire                sel_lost;

    // lowest set bit index; bit position equals default priority
    function [`IDX_W-1:0] lowest_set;
        input [`NUM_SRC-1:0] v;
        integer i;
        begin
            lowest_set = {`IDX_W{1'b0}};
            for (i = `NUM_SRC - 1; i >= 0; i = i - 1) begin
                if (v[i]) begin
                    lowest_set = i[`IDX_W-1:0];
                end
            end
        end
    endfunction

    assign wdt_thresh = wdt_overflow_i - {2'b00, wdt_overflow_i[`WDT_W-1:2]};
    // count may sit on the threshold for many cycles, so fire only on arrival
    assign wdt_hit = (wdt_count_i == wdt_thresh) && (wdt_prev_q != wdt_thresh);

    assign pin_raw = {ext_pin_ten_irq_i, ext_pin_five_irq_i, ext_pin_four_irq_i, ext_pin_zero_irq_i};

    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : g_pin
            pin_edge_sync u_sync (
                .clk_i     (clk_i),
                .resetn_i  (resetn_i),
                .ce_i      (ce_i),
                .pin_i     (pin_raw[g]),
                .rise_en_i (pin_rise_en_i[g]),
                .fall_en_i (pin_fall_en_i[g]),
                .edge_o    (pin_edge[g])
            );
        end
    endgenerate

    always @* begin
        ev = {`NUM_SRC{1'b0}};
        ev[0]  = wdt_hit & option_byte_i[`OPT_WDT_EN_BIT];
        ev[1]  = low_voltage_irq_i & ~low_voltage_detect_reg_i[`LVI_MODE_BIT];
        ev[2]  = pin_edge[0];
        ev[3]  = pin_edge[1];
        ev[4]  = pin_edge[2];
        ev[5]  = lin_port_tx_irq_i;
        ev[6]  = lin_port_rx_irq_i;
        ev[7]  = lin_port_rx_err_irq_i;
        ev[8]  = dma_ch_zero_done_irq_i;
        ev[9]  = dma_ch_one_done_irq_i;
        ev[10] = radio_link_serial_irq_i | radio_link_buf_empty_i;
        ev[11] = multi_port_async_tx_irq_i | multi_port_sync_irq_i
               | multi_port_sync_empty_i | multi_port_twowire_irq_i;
        ev[12] = multi_port_rx_irq_i;
        ev[13] = multi_port_rx_err_irq_i;
        ev[14] = timer_u0_ch0_irq_i;
        ev[15] = timer_u0_ch1_irq_i;
        ev[16] = timer_u0_ch2_irq_i;
        ev[17] = timer_u0_ch3_irq_i;
        ev[18] = rtc_fixed_cycle_i | rtc_alarm_match_i;
        ev[19] = rtc_interval_irq_i;
        ev[20] = tx_only_port_irq_i;
        ev[21] = timer_u1_ch3_irq_i;
        ev[22] = timer_u0_ch4_irq_i;
        ev[23] = timer_u0_ch5_irq_i;
        ev[24] = timer_u0_ch6_irq_i;
        ev[25] = timer_u0_ch7_irq_i;
        ev[26] = pin_edge[3];
        ev[27] = timer_u1_ch0_irq_i;
        ev[28] = timer_u1_ch1_irq_i;
        ev[29] = timer_u1_ch2_irq_i;
        ev[30] = divide_done_irq_i;
    end

    assign cand     = cpu_int_enable_i ? (pend_q & ~mask_i) : {`NUM_SRC{1'b0}};
    assign cand_any = |cand;
    assign winner   = lowest_set(cand);
    // a presented maskable request is withdrawn if masked or cleared meanwhile
    assign sel_lost = ~int_software_o & (mask_i[idx_q] | ~cpu_int_enable_i | ~pend_q[idx_q]);

    vector_rom u_rom (
        .clk_i    (clk_i),
        .resetn_i (resetn_i),
        .ce_i     (ce_i),
        .addr_i   (idx_q),
        .rdata_o  (rom_data)
    );

    always @* begin
        ack_clr = {`NUM_SRC{1'b0}};
        if ((state_q == ST_PRESENT) && cpu_ack_i && !int_software_o) begin
            ack_clr[idx_q] = 1'b1;
        end
        // set wins over any clear in the same cycle
        pend_d = (pend_q & ~(flag_clear_i | ack_clr)) | ev;
        sw_pend_d = software_break_instruction_i
                  | (sw_pend_q & ~((state_q == ST_PRESENT) & cpu_ack_i & int_software_o));
    end

    always @* begin
        state_d = state_q;
        idx_d   = idx_q;
        is_sw_d = int_software_o;
        req_d   = int_req_o;
        vec_d   = int_vector_o;
        prio_d  = int_priority_o;
        case (state_q)
            ST_IDLE: begin
                // software interrupt ignores masks and enable
                if (sw_pend_q) begin
                    is_sw_d = 1'b1;
                    vec_d   = `BRK_VECTOR;
                    prio_d  = {`IDX_W{1'b0}};
                    req_d   = 1'b1;
                    state_d = ST_PRESENT;
                end else if (cand_any) begin
                    is_sw_d = 1'b0;
                    idx_d   = winner;
                    state_d = ST_FETCH;
                end
            end
            ST_FETCH: begin
                state_d = ST_LOAD;
            end
            ST_LOAD: begin
                vec_d   = rom_data;
                prio_d  = idx_q;
                req_d   = 1'b1;
                state_d = ST_PRESENT;
            end
            ST_PRESENT: begin
                if (cpu_ack_i || sel_lost) begin
                    req_d   = 1'b0;
                    state_d = ST_IDLE;
                end
            end
            default: begin
                req_d   = 1'b0;
                state_d = ST_IDLE;
            end
        endcase
    end

    always @(posedge clk_i) begin
        if (!resetn_i) begin
            state_q        <= ST_IDLE;
            pend_q         <= {`NUM_SRC{1'b0}};
            sw_pend_q      <= 1'b0;
            idx_q          <= {`IDX_W{1'b0}};
            wdt_prev_q     <= {`WDT_W{1'b0}};
            int_req_o      <= 1'b0;
            int_vector_o   <= `IDLE_VECTOR;
            int_priority_o <= {`IDX_W{1'b0}};
            int_software_o <= 1'b0;
            pending_o      <= {`NUM_SRC{1'b0}};
        end else if (ce_i) begin
            state_q        <= state_d;
            pend_q         <= pend_d;
            sw_pend_q      <= sw_pend_d;
            idx_q          <= idx_d;
            wdt_prev_q     <= wdt_count_i;
            int_req_o      <= req_d;
            int_vector_o   <= vec_d;
            int_priority_o <= prio_d;
            int_software_o <= is_sw_d;
            pending_o      <= pend_d;
        end
    end
endmodule // vectored_interrupt_priority

// ==== irq_consts.vh ====
// constants for the vectored interrupt priority logic
`ifndef IRQ_CONSTS_VH
`define IRQ_CONSTS_VH

`define NUM_SRC        31
`define IDX_W          5
`define VEC_W          16
`define WDT_W          16
`define OPT_BYTE_ADDR  16'h00C0
`define OPT_WDT_EN_BIT 7
`define LVI_MODE_BIT   1
`define BRK_VECTOR     16'h0060
`define IDLE_VECTOR    16'h0000
`define VEC_00 16'h0004
`define VEC_01 16'h0006
`define VEC_02 16'h0008
`define VEC_03 16'h0010
`define VEC_04 16'h0012
`define VEC_05 16'h0014
`define VEC_06 16'h0016
`define VEC_07 16'h0018
`define VEC_08 16'h001A
`define VEC_09 16'h001C
`define VEC_10 16'h001E
`define VEC_11 16'h0024
`define VEC_12 16'h0026
`define VEC_13 16'h0028
`define VEC_14 16'h002C
`define VEC_15 16'h002E
`define VEC_16 16'h0030
`define VEC_17 16'h0032
`define VEC_18 16'h0036
`define VEC_19 16'h0038
`define VEC_20 16'h003C
`define VEC_21 16'h0040
`define VEC_22 16'h0042
`define VEC_23 16'h0044
`define VEC_24 16'h0046
`define VEC_25 16'h0048
`define VEC_26 16'h0052
`define VEC_27 16'h0056
`define VEC_28 16'h0058
`define VEC_29 16'h005A
`define VEC_30 16'h005E

`endif

// ==== vector_rom.v ====
// vector table lookup with registered read data
`timescale 1ns/1ps
`include "irq_consts.vh"
module vector_rom (
    input  wire               clk_i,
    input  wire               resetn_i,
    input  wire               ce_i,
    input  wire [`IDX_W-1:0]  addr_i,
    output reg  [`VEC_W-1:0]  rdata_o
);
    always @(posedge clk_i) begin
        if (!resetn_i) begin
            rdata_o <= `IDLE_VECTOR;
        end else if (ce_i) begin
            case (addr_i)
                5'h00: rdata_o <= `VEC_00;
                5'h01: rdata_o <= `VEC_01;
                5'h02: rdata_o <= `VEC_02;
                5'h03: rdata_o <= `VEC_03;
                5'h04: rdata_o <= `VEC_04;
                5'h05: rdata_o <= `VEC_05;
                5'h06: rdata_o <= `VEC_06;
                5'h07: rdata_o <= `VEC_07;
                5'h08: rdata_o <= `VEC_08;
                5'h09: rdata_o <= `VEC_09;
                5'h0a: rdata_o <= `VEC_10;
                5'h0b: rdata_o <= `VEC_11;
                5'h0c: rdata_o <= `VEC_12;
                5'h0d: rdata_o <= `VEC_13;
                5'h0e: rdata_o <= `VEC_14;
                5'h0f: rdata_o <= `VEC_15;
                5'h10: rdata_o <= `VEC_16;
                5'h11: rdata_o <= `VEC_17;
                5'h12: rdata_o <= `VEC_18;
                5'h13: rdata_o <= `VEC_19;
                5'h14: rdata_o <= `VEC_20;
                5'h15: rdata_o <= `VEC_21;
                5'h16: rdata_o <= `VEC_22;
                5'h17: rdata_o <= `VEC_23;
                5'h18: rdata_o <= `VEC_24;
                5'h19: rdata_o <= `VEC_25;
                5'h1a: rdata_o <= `VEC_26;
                5'h1b: rdata_o <= `VEC_27;
                5'h1c: rdata_o <= `VEC_28;
                5'h1d: rdata_o <= `VEC_29;
                5'h1e: rdata_o <= `VEC_30;
                default: rdata_o <= `IDLE_VECTOR;
            endcase
        end
    end
endmodule // vector_rom

// ==== pin_edge_sync.v ====
// three-flop pin synchroniser with selectable edge detection
`timescale 1ns/1ps
module pin_edge_sync (
    input  wire clk_i,
    input  wire resetn_i,
    input  wire ce_i,
    input  wire pin_i,
    input  wire rise_en_i,
    input  wire fall_en_i,
    output reg  edge_o
);
    reg s1_q;
    reg s2_q;
    reg s3_q;
    reg level_q;
    reg primed_q;
    reg [1:0] fill_q;

    // first level after reset is taken quietly, so a pin held high gives no edge
    always @(posedge clk_i) begin
        if (!resetn_i) begin
            s1_q     <= 1'b0;
            s2_q     <= 1'b0;
            s3_q     <= 1'b0;
            level_q  <= 1'b0;
            primed_q <= 1'b0;
            fill_q   <= 2'h0;
            edge_o   <= 1'b0;
        end else if (ce_i) begin
            s1_q   <= pin_i;
            s2_q   <= s1_q;
            s3_q   <= s2_q;
            edge_o <= 1'b0;
            // reset values of the flops are not pin samples, so wait until the chain is filled
            if (fill_q != 2'h3) begin
                fill_q <= fill_q + 2'h1;
            end
            if ((fill_q == 2'h3) && (s2_q == s3_q)) begin
                primed_q <= 1'b1;
                level_q  <= s3_q;
                if (primed_q && (s3_q != level_q)) begin
                    edge_o <= s3_q ? rise_en_i : fall_en_i;
                end
            end
        end
    end
endmodule // pin_edge_sync

// ==== vip_asserts.sv ====
// port assertions for the vectored interrupt priority resolver
`timescale 1ns/1ps
`include "irq_consts.vh"
module vip_asserts (
    input wire logic                clk_i,
    input wire logic                resetn_i,
    input wire logic                ce_i,
    input wire logic [7:0]          option_byte_i,
    input wire logic [7:0]          low_voltage_detect_reg_i,
    input wire logic [`NUM_SRC-1:0] mask_i,
    input wire logic                cpu_ack_i,
    input wire logic                int_req_o,
    input wire logic [`VEC_W-1:0]   int_vector_o,
    input wire logic [`IDX_W-1:0]   int_priority_o,
    input wire logic                int_software_o,
    input wire logic [`NUM_SRC-1:0] pending_o
);
    // vector per priority, priority 30 first
    localparam logic [16*`NUM_SRC-1:0] VT = {
        16'h005E, 16'h005A, 16'h0058, 16'h0056, 16'h0052, 16'h0048, 16'h0046, 16'h0044, 16'h0042, 16'h0040,
        16'h003C, 16'h0038, 16'h0036, 16'h0032, 16'h0030, 16'h002E, 16'h002C, 16'h0028, 16'h0026, 16'h0024,
        16'h001E, 16'h001C, 16'h001A, 16'h0018, 16'h0016, 16'h0014, 16'h0012, 16'h0010, 16'h0008, 16'h0006,
        16'h0004};
    logic [`NUM_SRC-1:0] lower_m;
    // bits below the presented priority
    assign lower_m = (31'h1 << int_priority_o) - 31'h1;

    default clocking @(posedge clk_i); endclocking
    default disable iff (!resetn_i);

    a_vector_by_prio: assert property (
        int_req_o && !int_software_o |-> int_vector_o == VT[16*int_priority_o +: 16])
        else $error("vector does not match priority");
    a_soft_vector: assert property (
        int_req_o && int_software_o |-> int_vector_o == `BRK_VECTOR && int_priority_o == 5'h0)
        else $error("software request shows wrong vector");
    a_ack_drops_req: assert property (
        int_req_o && cpu_ack_i && ce_i |=> !int_req_o)
        else $error("request stands after acknowledge");
    a_ack_clears_flag: assert property (
        int_req_o && cpu_ack_i && ce_i && !int_software_o |=> !pending_o[$past(int_priority_o)])
        else $error("accepted flag not cleared");
    a_mask_withdraws: assert property (
        int_req_o && !int_software_o && ce_i && mask_i[int_priority_o] |=> !int_req_o)
        else $error("masked request still presented");
    a_gap_after_drop: assert property (
        $fell(int_req_o) |=> !int_req_o)
        else $error("request presented without idle cycle");
    a_lowest_wins: assert property (
        $rose(int_req_o) && !int_software_o |-> (($past(pending_o, 3) & ~$past(mask_i, 3)) & lower_m) == '0)
        else $error("lower priority number was waiting");
    a_wdt_gated: assert property (
        $rose(pending_o[0]) |-> $past(option_byte_i[7]))
        else $error("watchdog flag set while disabled");
    a_lvi_gated: assert property (
        $rose(pending_o[1]) |-> !$past(low_voltage_detect_reg_i[1]))
        else $error("low-voltage flag set in reset mode");

    c_soft_taken: cover property (int_req_o && int_software_o && cpu_ack_i);
    c_mask_taken: cover property (int_req_o && !int_software_o && cpu_ack_i);
    c_masked_wait: cover property (pending_o[20] && mask_i[20]);
endmodule // vip_asserts

bind vectored_interrupt_priority vip_asserts u_vip_asserts (
    .clk_i(clk_i), .resetn_i(resetn_i), .ce_i(ce_i), .option_byte_i(option_byte_i),
    .low_voltage_detect_reg_i(low_voltage_detect_reg_i), .mask_i(mask_i), .cpu_ack_i(cpu_ack_i),
    .int_req_o(int_req_o), .int_vector_o(int_vector_o), .int_priority_o(int_priority_o),
    .int_software_o(int_software_o), .pending_o(pending_o));

// ==== cpu_core_model.sv ====
// cpu core side: accepts a presented interrupt after a chosen delay
`timescale 1ns/1ps
module cpu_core_model (
    input  wire logic       clk_i,
    input  wire logic       resetn_i,
    input  wire logic       int_req_i,
    input  wire logic [1:0] delay_i,
    output logic            cpu_ack_o
);
    logic [1:0] wait_q;
    initial cpu_ack_o = 1'b0;
    initial wait_q = 2'h0;
    // ack stands one cycle: the request drops after the edge that samples it
    always @(posedge clk_i) begin
        if (!resetn_i || cpu_ack_o || !int_req_i) begin
            cpu_ack_o <= #1 1'b0;
            wait_q    <= #1 2'h0;
        end else if (wait_q == delay_i) begin
            cpu_ack_o <= #1 1'b1;
        end else begin
            wait_q <= #1 wait_q + 2'h1;
        end
    end
endmodule // cpu_core_model

// ==== testbench.sv ====
// self-checking bench for the vectored interrupt priority resolver
`timescale 1ns/1ps
`include "irq_consts.vh"
module testbench;
    localparam logic [15:0] OVF  = 16'h0040;
    localparam logic [15:0] THR  = OVF - (OVF >> 2);
    localparam logic [30:0] SAFE = 31'h7BFF_FFE2;
    logic        clk_i = 1'b0, resetn_i = 1'b0, software_break_instruction = 1'b0, int_en = 1'b1, ce = 1'b1;
    logic [15:0] wdt_count = 16'h0000;
    logic [7:0]  option_byte = 8'h80, lvd_reg = 8'h00;
    logic [30:0] ev = '0, mask = '0, clr = '0, r;
    logic [3:0]  pin = 4'h0, rise_en = 4'hF, fall_en = 4'h0;
    logic [1:0]  alt = 2'h0, delay = 2'h0;
    logic        cpu_ack, int_req, int_sw;
    logic [15:0] int_vec;
    logic [4:0]  int_prio;
    logic [30:0] pend;
    logic [21:0] exp_q[$];
    logic [21:0] exp_e;
    integer      mismatches = 0, checks = 0, seed = 32'h68e7, i, n;
    logic [15:0] vt [0:30] = '{16'h0004, 16'h0006, 16'h0008, 16'h0010, 16'h0012, 16'h0014, 16'h0016,
        16'h0018, 16'h001A, 16'h001C, 16'h001E, 16'h0024, 16'h0026, 16'h0028, 16'h002C, 16'h002E, 16'h0030,
        16'h0032, 16'h0036, 16'h0038, 16'h003C, 16'h0040, 16'h0042, 16'h0044, 16'h0046, 16'h0048, 16'h0052,
        16'h0056, 16'h0058, 16'h005A, 16'h005E};

    always #10 clk_i = ~clk_i;

    vectored_interrupt_priority u_vectored_interrupt_priority (
        .clk_i(clk_i), .resetn_i(resetn_i), .ce_i(ce), .wdt_count_i(wdt_count), .wdt_overflow_i(OVF),
        .option_byte_i(option_byte), .low_voltage_detect_reg_i(lvd_reg), .low_voltage_irq_i(ev[1]),
        .ext_pin_zero_irq_i(pin[0]), .ext_pin_four_irq_i(pin[1]), .ext_pin_five_irq_i(pin[2]),
        .ext_pin_ten_irq_i(pin[3]), .pin_rise_en_i(rise_en), .pin_fall_en_i(fall_en),
        .lin_port_tx_irq_i(ev[5]), .lin_port_rx_irq_i(ev[6]), .lin_port_rx_err_irq_i(ev[7]),
        .dma_ch_zero_done_irq_i(ev[8]), .dma_ch_one_done_irq_i(ev[9]),
        .radio_link_serial_irq_i(ev[10] & ~alt[0]), .radio_link_buf_empty_i(ev[10] & alt[0]),
        .multi_port_async_tx_irq_i(ev[11] && alt == 2'h0), .multi_port_sync_irq_i(ev[11] && alt == 2'h1),
        .multi_port_sync_empty_i(ev[11] && alt == 2'h2), .multi_port_twowire_irq_i(ev[11] && alt == 2'h3),
        .multi_port_rx_irq_i(ev[12]), .multi_port_rx_err_irq_i(ev[13]),
        .timer_u0_ch0_irq_i(ev[14]), .timer_u0_ch1_irq_i(ev[15]), .timer_u0_ch2_irq_i(ev[16]),
        .timer_u0_ch3_irq_i(ev[17]), .timer_u0_ch4_irq_i(ev[22]), .timer_u0_ch5_irq_i(ev[23]),
        .timer_u0_ch6_irq_i(ev[24]), .timer_u0_ch7_irq_i(ev[25]), .timer_u1_ch0_irq_i(ev[27]),
        .timer_u1_ch1_irq_i(ev[28]), .timer_u1_ch2_irq_i(ev[29]), .timer_u1_ch3_irq_i(ev[21]),
        .rtc_fixed_cycle_i(ev[18] & ~alt[0]), .rtc_alarm_match_i(ev[18] & alt[0]), .rtc_interval_irq_i(ev[19]),
        .tx_only_port_irq_i(ev[20]), .divide_done_irq_i(ev[30]), .software_break_instruction_i(software_break_instruction),
        .mask_i(mask), .flag_clear_i(clr), .cpu_int_enable_i(int_en), .cpu_ack_i(cpu_ack),
        .int_req_o(int_req), .int_vector_o(int_vec), .int_priority_o(int_prio), .int_software_o(int_sw),
        .pending_o(pend));

    cpu_core_model u_cpu_core_model (.clk_i(clk_i), .resetn_i(resetn_i), .int_req_i(int_req),
        .delay_i(delay), .cpu_ack_o(cpu_ack));

    task automatic tick;
        @(posedge clk_i);
        #1;
    endtask
    task automatic check(input string what, input logic [31:0] exp_v, input logic [31:0] got_v);
        checks = checks + 1;
        if (got_v !== exp_v) begin
            $display("wrong value %s expected %h seen %h", what, exp_v, got_v);
            mismatches = mismatches + 1;
        end
    endtask
    task automatic end_of_test;
        if (mismatches == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic expect_irq(input integer p);
        exp_q.push_back({1'b0, p[4:0], vt[p]});
    endtask
    // bounded wait until every note is matched, then the idle gap before the next round
    task automatic settle;
        for (n = 0; n < 400 && exp_q.size() != 0; n = n + 1) tick;
        if (n == 400) begin
            mismatches = mismatches + 1;
            end_of_test;
        end
        repeat (3) tick;
    endtask
    // pins only rise once, so each pin source can be fired a single time
    task automatic fire(input integer p);
        case (p)
            0: wdt_count = THR;
            2: pin[0] = 1'b1;
            3: pin[1] = 1'b1;
            4: pin[2] = 1'b1;
            26: pin[3] = 1'b1;
            default: ev[p] = 1'b1;
        endcase
        tick;
        ev = '0;
    endtask

    // result watcher: each accepted request against the oldest note
    always @(posedge clk_i) begin
        if (resetn_i && int_req && cpu_ack) begin
            if (exp_q.size() == 0) begin
                check("unexpected request", 32'h0, 32'h1);
            end else begin
                exp_e = exp_q.pop_front();
                check("presented request", {10'h0, exp_e}, {10'h0, int_sw, int_prio, int_vec});
            end
        end
    end

    initial begin
        repeat (10) tick;
        resetn_i = 1'b1;
        tick;
        check("idle after reset", 32'h0, {int_req, int_sw, pend});
        repeat (4) tick;
        for (i = 0; i < 31; i = i + 1) begin
            alt = i[1:0];
            delay = i[1:0];
            expect_irq(i);
            fire(i);
            settle;
            check("flag after accept", 32'h0, pend[i]);
        end
        for (i = 0; i < 6; i = i + 1) begin
            r = 31'($random(seed)) & SAFE;
            alt = 2'($random(seed));
            delay = 2'($random(seed));
            for (n = 0; n < 31; n = n + 1) if (r[n]) expect_irq(n);
            ev = r;
            tick;
            ev = '0;
            settle;
        end
        mask[20] = 1'b1;
        int_en = 1'b0;
        fire(20);
        fire(15);
        repeat (8) tick;
        check("masked flag kept", 32'h1, pend[20]);
        expect_irq(15);
        int_en = 1'b1;
        settle;
        clr[20] = 1'b1;
        tick;
        clr = '0;
        repeat (2) tick;
        check("flag cleared", 32'h0, pend[20]);
        mask = '0;
        delay = 2'h3;
        expect_irq(16);
        fire(16);
        for (n = 0; n < 20 && int_req !== 1'b1; n = n + 1) tick;
        if (n == 20) begin
            mismatches = mismatches + 1;
            end_of_test;
        end
        mask[16] = 1'b1;
        tick;
        mask = '0;
        settle;
        // falling edge on pin zero, which was left high
        fall_en = 4'h1;
        expect_irq(2);
        pin[0] = 1'b0;
        settle;
        // clock enable low: an event pulse is not taken
        ce = 1'b0;
        fire(5);
        ce = 1'b1;
        repeat (3) tick;
        check("frozen while disabled", 32'h0, pend[5]);
        option_byte = 8'h7F;
        wdt_count = 16'h0000;
        tick;
        fire(0);
        lvd_reg = 8'h02;
        fire(1);
        repeat (8) tick;
        check("watchdog gated", 32'h0, pend[0]);
        check("low voltage gated", 32'h0, pend[1]);
        int_en = 1'b0;
        mask = '1;
        exp_q.push_back({1'b1, 5'h00, `BRK_VECTOR});
        software_break_instruction = 1'b1;
        tick;
        software_break_instruction = 1'b0;
        settle;
        int_en = 1'b1;
        mask = '0;
        exp_q.push_back({1'b1, 5'h00, `BRK_VECTOR});
        expect_irq(14);
        software_break_instruction = 1'b1;
        ev[14] = 1'b1;
        tick;
        software_break_instruction = 1'b0;
        ev = '0;
        settle;
        end_of_test;
    end
endmodule // testbench
